/* File: tsq_pkg.sv */
// Package: constants, states and timing for the two-wire transfer sequencer
`default_nettype none
package tsq_pkg;
   // System clock period
   localparam int CLK_PERIOD_NS = 8;
   // Bus intervals in ns: start hold and stop setup, serial clock low phase
   localparam int T_HOLD_STD_NS = 4000;
   localparam int T_HOLD_FAST_NS = 600;
   localparam int T_LOW_STD_NS = 4700;
   localparam int T_LOW_FAST_NS = 1300;
   localparam int CNT_W = 10;
   // Least times rounded up to whole clock cycles
   localparam logic [9:0] HOLD_STD_CYC =
      10'((T_HOLD_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [9:0] HOLD_FAST_CYC =
      10'((T_HOLD_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [9:0] LOW_STD_CYC =
      10'((T_LOW_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [9:0] LOW_FAST_CYC =
      10'((T_LOW_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [9:0] CNT_ZERO_CYC = 10'h000;
   // Serial clock counts within a byte
   localparam logic [3:0] CLK_NONE = 4'h0;
   localparam logic [3:0] CLK_FIRST = 4'h1;
   localparam logic [3:0] CLK_LAST_DATA = 4'h8;
   localparam logic [3:0] CLK_ACK = 4'h9;
   localparam logic [7:0] ALL_ONES = 8'hff;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // Status register bit positions
   localparam int BIT_MASTER = 7;
   localparam int BIT_LOST = 6;
   localparam int BIT_EXT = 5;
   localparam int BIT_ADDRESSED = 4;
   localparam int BIT_DIR = 3;
   localparam int BIT_ACKD = 2;
   localparam int BIT_START = 1;
   localparam int BIT_STOP = 0;
   // Bus sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_START_SETUP = 3'b001,
      ST_START_HOLD = 3'b010,
      ST_BYTE = 3'b011,
      ST_STOP_LOW = 3'b100,
      ST_STOP_SETUP = 3'b101
   } tsq_state_t;
endpackage
`default_nettype wire

/* File: tsq_interval_timer.sv */
// Down counter that times bus intervals in system clock cycles
`default_nettype none
module tsq_interval_timer (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // Load strobe and cycle count
   input wire logic load_in,
   input wire logic [9:0] count_in,
   // Interval elapsed
   output logic done_out
);
   logic [9:0] cnt_reg;

   // Load on strobe, then count down to zero and hold
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         cnt_reg <= tsq_pkg::CNT_ZERO_CYC;
      end else if (load_in) begin
         cnt_reg <= count_in;
      end else if (cnt_reg != tsq_pkg::CNT_ZERO_CYC) begin
         cnt_reg <= cnt_reg - 10'h001;
      end
   end

   // A pending load hides a stale zero
   assign done_out = (cnt_reg == tsq_pkg::CNT_ZERO_CYC) && !load_in;
endmodule
`default_nettype wire

/* File: tsq_link_front.sv */
// Pin sampler on the link clock with event crossing into the system clock
`default_nettype none
module tsq_link_front (
   // System clock domain
   input wire logic clk_in,
   input wire logic reset_in,
   // Link clock and raw pins
   input wire logic link_clk_in,
   input wire logic scl_pin_in,
   input wire logic sda_pin_in,
   // Levels and one-cycle events in the system domain; the rise data sample stays on the link clock
   output logic scl_level_out,
   output logic sda_level_out,
   output logic rise_out,
   output logic fall_out,
   output logic start_out,
   output logic stop_out,
   output logic rise_sample_out
);
   logic lrst_meta, lrst_reg;
   logic [1:0] scl_sync_reg, sda_sync_reg;
   logic scl_prev_reg, sda_prev_reg, sample_reg;
   logic [3:0] ev_hit, tgl_reg, tgl_meta, tgl_sync_reg, tgl_prev_reg;
   logic [1:0] lvl_meta, lvl_sync_reg;

   // Reset brought into the link domain
   always_ff @(posedge link_clk_in) begin
      lrst_meta <= reset_in;
      lrst_reg <= lrst_meta;
   end

   // Two-stage pin synchronisers and previous levels
   always_ff @(posedge link_clk_in) begin
      scl_sync_reg <= {scl_sync_reg[0], scl_pin_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_pin_in};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
   end

   // Rise, fall, start and stop seen on the bus
   assign ev_hit[0] = scl_sync_reg[1] && !scl_prev_reg;
   assign ev_hit[1] = !scl_sync_reg[1] && scl_prev_reg;
   assign ev_hit[2] = scl_sync_reg[1] && scl_prev_reg && sda_prev_reg && !sda_sync_reg[1];
   assign ev_hit[3] = scl_sync_reg[1] && scl_prev_reg && !sda_prev_reg && sda_sync_reg[1];

   // Events become toggles; data bit caught at each clock rise
   always_ff @(posedge link_clk_in) begin
      if (lrst_reg) begin
         tgl_reg <= 4'h0;
         sample_reg <= 1'b1;
      end else begin
         tgl_reg <= tgl_reg ^ ev_hit;
         if (ev_hit[0]) begin
            sample_reg <= sda_sync_reg[1];
         end
      end
   end

   // Toggle and level synchronisers in the system domain
   always_ff @(posedge clk_in) begin
      tgl_meta <= tgl_reg;
      lvl_meta <= {scl_sync_reg[1], sda_sync_reg[1]};
      if (reset_in) begin
         tgl_sync_reg <= 4'h0;
         tgl_prev_reg <= 4'h0;
         lvl_sync_reg <= 2'b11;
      end else begin
         tgl_sync_reg <= tgl_meta;
         tgl_prev_reg <= tgl_sync_reg;
         lvl_sync_reg <= lvl_meta;
      end
   end

   // Sample is stable for microseconds around its rise event
   assign rise_out = tgl_sync_reg[0] ^ tgl_prev_reg[0];
   assign fall_out = tgl_sync_reg[1] ^ tgl_prev_reg[1];
   assign start_out = tgl_sync_reg[2] ^ tgl_prev_reg[2];
   assign stop_out = tgl_sync_reg[3] ^ tgl_prev_reg[3];
   assign scl_level_out = lvl_sync_reg[1];
   assign sda_level_out = lvl_sync_reg[0];
   assign rise_sample_out = sample_reg;
endmodule
`default_nettype wire

/* File: tsq_transfer_sequencer.sv */
// Two-wire master and slave transfer sequencer, top level
`default_nettype none
module tsq_transfer_sequencer (
   // System clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // Link clock that samples the bus pins
   input wire logic link_clk_in,
   // Serial clock line pin
   input wire logic serial_clock_line_in,
   output logic serial_clock_line_out,
   output logic serial_clock_line_oe_out,
   // Serial data line pin
   input wire logic serial_data_line_in,
   output logic serial_data_line_out,
   output logic serial_data_line_oe_out,
   // Software control
   input wire logic start_trigger_bit_in,
   input wire logic stop_trigger_bit_in,
   input wire logic wait_release_bit_in,
   input wire logic shift_write_in,
   input wire logic [7:0] shift_write_data_in,
   input wire logic ack_enable_bit_in,
   input wire logic wait_timing_select_in,
   input wire logic stop_interrupt_enable_in,
   input wire logic fast_mode_in,
   input wire logic [6:0] own_slave_address_in,
   // Software status
   output logic [7:0] serial_shift_register_out,
   output logic [7:0] bus_status_register_out,
   output logic wait_active_out,
   output logic bus_event_interrupt_out
);
   tsq_pkg::tsq_state_t state_reg;
   logic master_reg, addressed_reg, dir_tx_reg, ackd_reg, busy_reg, stop_seen_reg;
   logic addr_phase_reg, match_reg, wait_reg, out_latch_reg, irq_reg;
   logic scl_oe_reg, sda_oe_reg, pin_low_reg, tmr_load_reg;
   logic [3:0] clk_cnt_reg;
   logic [7:0] sreg_reg, rdata_reg, status_reg;
   logic [9:0] tmr_count_reg, hold_cyc, low_cyc;
   logic scl_lvl, sda_lvl, ev_rise, ev_fall, ev_start, ev_stop, rise_sample, tmr_done;
   logic transmitter, participating, addr_match, ack_now, load_byte;
   logic release_tx, release_rx, fall8, fall9, wait_set, byte_irq;

   // Pick the standard or fast mode count
   function automatic logic [9:0] pick_count(input logic fast, input logic [9:0] std_c,
                                             input logic [9:0] fast_c);
      pick_count = fast ? fast_c : std_c;
   endfunction

   // Bus pin front end on the link clock
   tsq_link_front front (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .link_clk_in(link_clk_in),
      .scl_pin_in(serial_clock_line_in),
      .sda_pin_in(serial_data_line_in),
      .scl_level_out(scl_lvl),
      .sda_level_out(sda_lvl),
      .rise_out(ev_rise),
      .fall_out(ev_fall),
      .start_out(ev_start),
      .stop_out(ev_stop),
      .rise_sample_out(rise_sample)
   );

   // Interval timer for start hold, stop setup and clock phases
   tsq_interval_timer timer (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .load_in(tmr_load_reg),
      .count_in(tmr_count_reg),
      .done_out(tmr_done)
   );

   // Speed dependent counts
   assign hold_cyc = pick_count(fast_mode_in, tsq_pkg::HOLD_STD_CYC,
                                tsq_pkg::HOLD_FAST_CYC);
   assign low_cyc = pick_count(fast_mode_in, tsq_pkg::LOW_STD_CYC, tsq_pkg::LOW_FAST_CYC);

   // Role in the current byte and decisions at clock edges
   assign transmitter = addr_phase_reg ? master_reg : dir_tx_reg;
   assign participating = master_reg || addressed_reg;
   assign addr_match = (sreg_reg[7:1] == own_slave_address_in) && !master_reg;
   assign ack_now = addr_phase_reg ? addr_match
                                   : (!transmitter && participating && ack_enable_bit_in);
   assign load_byte = shift_write_in && wait_reg && participating &&
                      (clk_cnt_reg == tsq_pkg::CLK_NONE);
   assign release_tx = wait_reg && transmitter && shift_write_in;
   assign release_rx = wait_reg && !transmitter && (wait_release_bit_in ||
                       (shift_write_in && shift_write_data_in == tsq_pkg::ALL_ONES));
   assign fall8 = ev_fall && (clk_cnt_reg == tsq_pkg::CLK_LAST_DATA);
   assign fall9 = ev_fall && (clk_cnt_reg == tsq_pkg::CLK_ACK);

   // Wait points and the interrupts that come with them
   always_comb begin
      byte_irq = 1'b0;
      if (fall9 && addr_phase_reg) begin
         byte_irq = master_reg || match_reg;
      end else if (fall9 && participating && wait_timing_select_in) begin
         byte_irq = 1'b1;
      end else if (fall8 && !addr_phase_reg && participating && !wait_timing_select_in) begin
         byte_irq = 1'b1;
      end
      wait_set = byte_irq || (ev_fall && master_reg && addr_phase_reg &&
                              clk_cnt_reg == tsq_pkg::CLK_NONE);
   end

   // Count serial clocks within a byte
   always_ff @(posedge clk_in) begin
      if (reset_in || ev_start || ev_stop) begin
         clk_cnt_reg <= tsq_pkg::CLK_NONE;
      end else if (ev_rise && clk_cnt_reg != tsq_pkg::CLK_ACK) begin
         clk_cnt_reg <= clk_cnt_reg + tsq_pkg::CLK_FIRST;
      end else if (fall9) begin
         clk_cnt_reg <= tsq_pkg::CLK_NONE;
      end
   end

   // Shift register: load by write, data bits taken in on rises
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         sreg_reg <= tsq_pkg::ALL_ONES;
      end else if (load_byte) begin
         sreg_reg <= shift_write_data_in;
      end else if (ev_rise && clk_cnt_reg < tsq_pkg::CLK_LAST_DATA) begin
         sreg_reg <= {sreg_reg[6:0], rise_sample};
      end
   end

   // Output latch toward the data line, most significant bit first
   always_ff @(posedge clk_in) begin
      if (reset_in || ev_start || ev_stop) begin
         out_latch_reg <= 1'b1;
      end else if (load_byte) begin
         out_latch_reg <= transmitter ? shift_write_data_in[7] : 1'b1;
      end else if (ev_fall && clk_cnt_reg >= tsq_pkg::CLK_FIRST &&
                   clk_cnt_reg < tsq_pkg::CLK_LAST_DATA) begin
         out_latch_reg <= transmitter ? sreg_reg[7] : 1'b1;
      end else if (fall8) begin
         out_latch_reg <= !ack_now;
      end else if (fall9) begin
         out_latch_reg <= 1'b1;
      end
   end

   // Address match kept from the eighth fall to the ninth
   always_ff @(posedge clk_in) begin
      if (reset_in || ev_start) begin
         match_reg <= 1'b0;
      end else if (fall8 && addr_phase_reg) begin
         match_reg <= addr_match;
      end
   end

   // Master, address phase and addressed flags
   always_ff @(posedge clk_in) begin
      if (reset_in || ev_stop) begin
         master_reg <= 1'b0;
         addr_phase_reg <= 1'b0;
         addressed_reg <= 1'b0;
      end else if (ev_start) begin
         master_reg <= (state_reg == tsq_pkg::ST_START_HOLD);
         addr_phase_reg <= 1'b1;
         addressed_reg <= 1'b0;
      end else if (fall9 && addr_phase_reg) begin
         addr_phase_reg <= 1'b0;
         addressed_reg <= match_reg;
      end
   end

   // Transfer direction flag
   always_ff @(posedge clk_in) begin
      if (reset_in || ev_stop) begin
         dir_tx_reg <= 1'b0;
      end else if (load_byte && addr_phase_reg && master_reg) begin
         dir_tx_reg <= !shift_write_data_in[0];
      end else if (fall9 && addr_phase_reg && match_reg) begin
         dir_tx_reg <= sreg_reg[0];
      end
   end

   // Acknowledge taken on the ninth rise by the transmitter, cleared by start and stop
   always_ff @(posedge clk_in) begin
      if (reset_in || ev_start || ev_stop) begin
         ackd_reg <= 1'b0;
      end else if (ev_rise && clk_cnt_reg == tsq_pkg::CLK_LAST_DATA && transmitter &&
                   participating) begin
         ackd_reg <= !rise_sample;
      end
   end

   // Wait state: a new wait point wins over a release
   always_ff @(posedge clk_in) begin
      if (reset_in || ev_start || ev_stop) begin
         wait_reg <= 1'b0;
      end else if (wait_set) begin
         wait_reg <= 1'b1;
      end else if (release_tx || release_rx) begin
         wait_reg <= 1'b0;
      end
   end

   // Bus busy and stop seen flags
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         busy_reg <= 1'b0;
         stop_seen_reg <= 1'b0;
      end else if (ev_start) begin
         busy_reg <= 1'b1;
         stop_seen_reg <= 1'b0;
      end else if (ev_stop) begin
         busy_reg <= 1'b0;
         stop_seen_reg <= 1'b1;
      end
   end

   // Interrupt pulse
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= byte_irq || (ev_stop && stop_interrupt_enable_in);
      end
   end

   // Bus sequencer: start, master clocking and stop
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_reg <= tsq_pkg::ST_IDLE;
         scl_oe_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         tmr_load_reg <= 1'b0;
         tmr_count_reg <= tsq_pkg::CNT_ZERO_CYC;
      end else begin
         tmr_load_reg <= 1'b0;
         case (state_reg)
            tsq_pkg::ST_IDLE: begin
               // Only a slave wait holds the clock here; a master wait ends with its stop
               scl_oe_reg <= wait_reg && !master_reg;
               sda_oe_reg <= !out_latch_reg;
               if (start_trigger_bit_in && !busy_reg) begin
                  state_reg <= tsq_pkg::ST_START_SETUP;
                  tmr_load_reg <= 1'b1;
                  tmr_count_reg <= hold_cyc;
               end
            end
            tsq_pkg::ST_START_SETUP: begin
               scl_oe_reg <= 1'b0;
               sda_oe_reg <= 1'b0;
               if (!(scl_lvl && sda_lvl)) begin
                  tmr_load_reg <= 1'b1;
                  tmr_count_reg <= hold_cyc;
               end else if (tmr_done) begin
                  sda_oe_reg <= 1'b1;
                  state_reg <= tsq_pkg::ST_START_HOLD;
                  tmr_load_reg <= 1'b1;
                  tmr_count_reg <= hold_cyc;
               end
            end
            tsq_pkg::ST_START_HOLD: begin
               if (tmr_done) begin
                  scl_oe_reg <= 1'b1;
                  state_reg <= tsq_pkg::ST_BYTE;
                  tmr_load_reg <= 1'b1;
                  tmr_count_reg <= low_cyc;
               end
            end
            tsq_pkg::ST_BYTE: begin
               sda_oe_reg <= !out_latch_reg;
               if (ev_stop) begin
                  state_reg <= tsq_pkg::ST_IDLE;
                  scl_oe_reg <= 1'b0;
               end else if (wait_reg && stop_trigger_bit_in) begin
                  state_reg <= tsq_pkg::ST_STOP_LOW;
                  tmr_load_reg <= 1'b1;
                  tmr_count_reg <= low_cyc;
               end else if (wait_reg && start_trigger_bit_in) begin
                  state_reg <= tsq_pkg::ST_START_SETUP;
                  tmr_load_reg <= 1'b1;
                  tmr_count_reg <= hold_cyc;
               end else if (!scl_oe_reg) begin
                  if (!scl_lvl) begin
                     tmr_load_reg <= 1'b1;
                     tmr_count_reg <= hold_cyc;
                  end else if (tmr_done) begin
                     scl_oe_reg <= 1'b1;
                     tmr_load_reg <= 1'b1;
                     tmr_count_reg <= low_cyc;
                  end
               end else if (wait_reg) begin
                  tmr_load_reg <= 1'b1;
                  tmr_count_reg <= low_cyc;
               end else if (tmr_done) begin
                  scl_oe_reg <= 1'b0;
               end
            end
            tsq_pkg::ST_STOP_LOW: begin
               sda_oe_reg <= 1'b1;
               if (tmr_done) begin
                  scl_oe_reg <= 1'b0;
                  state_reg <= tsq_pkg::ST_STOP_SETUP;
                  tmr_load_reg <= 1'b1;
                  tmr_count_reg <= hold_cyc;
               end
            end
            tsq_pkg::ST_STOP_SETUP: begin
               if (!scl_lvl) begin
                  tmr_load_reg <= 1'b1;
                  tmr_count_reg <= hold_cyc;
               end else if (tmr_done) begin
                  sda_oe_reg <= 1'b0;
                  state_reg <= tsq_pkg::ST_IDLE;
               end
            end
            default: begin
               state_reg <= tsq_pkg::ST_IDLE;
               scl_oe_reg <= 1'b0;
               sda_oe_reg <= 1'b0;
            end
         endcase
      end
   end

   // Status word and registered software outputs
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         status_reg <= tsq_pkg::STATUS_RESET;
         rdata_reg <= tsq_pkg::ALL_ONES;
         pin_low_reg <= 1'b0;
      end else begin
         status_reg[tsq_pkg::BIT_MASTER] <= master_reg;
         status_reg[tsq_pkg::BIT_LOST] <= 1'b0;
         status_reg[tsq_pkg::BIT_EXT] <= 1'b0;
         status_reg[tsq_pkg::BIT_ADDRESSED] <= addressed_reg;
         status_reg[tsq_pkg::BIT_DIR] <= dir_tx_reg;
         status_reg[tsq_pkg::BIT_ACKD] <= ackd_reg;
         status_reg[tsq_pkg::BIT_START] <= busy_reg;
         status_reg[tsq_pkg::BIT_STOP] <= stop_seen_reg;
         rdata_reg <= sreg_reg;
         pin_low_reg <= 1'b0;
      end
   end

   // Outputs, open drain: pins only ever pulled low
   assign serial_clock_line_out = pin_low_reg;
   assign serial_data_line_out = pin_low_reg;
   assign serial_clock_line_oe_out = scl_oe_reg;
   assign serial_data_line_oe_out = sda_oe_reg;
   assign serial_shift_register_out = rdata_reg;
   assign bus_status_register_out = status_reg;
   assign wait_active_out = wait_reg;
   assign bus_event_interrupt_out = irq_reg;
endmodule
`default_nettype wire

/* File: tsq_transfer_sequencer_properties.sv */
// Checker of bus timing and status relations of the transfer sequencer
`default_nettype none
module tsq_transfer_sequencer_properties (
   // Clock, reset and pins
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic serial_clock_line_in,
   input wire logic serial_clock_line_out,
   input wire logic serial_clock_line_oe_out,
   input wire logic serial_data_line_out,
   input wire logic serial_data_line_oe_out,
   // Software side
   input wire logic stop_trigger_bit_in,
   input wire logic wait_release_bit_in,
   input wire logic shift_write_in,
   input wire logic fast_mode_in,
   input wire logic [7:0] bus_status_register_out,
   input wire logic wait_active_out,
   input wire logic bus_event_interrupt_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   logic [9:0] low_cnt_reg;
   logic [9:0] high_cnt_reg;
   logic [9:0] hold_cyc;
   // Least hold for the selected speed
   assign hold_cyc = fast_mode_in ? tsq_pkg::HOLD_FAST_CYC : tsq_pkg::HOLD_STD_CYC;
   // Cycles with data pulled low and clock left free
   always_ff @(posedge clk_in) begin
      if (reset_in || !serial_data_line_oe_out || serial_clock_line_oe_out) low_cnt_reg <= '0;
      else if (low_cnt_reg != 10'h3ff) low_cnt_reg <= low_cnt_reg + 10'h001;
   end
   // Cycles with data pulled low and clock line high
   always_ff @(posedge clk_in) begin
      if (reset_in || !serial_data_line_oe_out || !serial_clock_line_in) high_cnt_reg <= '0;
      else if (high_cnt_reg != 10'h3ff) high_cnt_reg <= high_cnt_reg + 10'h001;
   end
   a_start_hold_time: assert property (bus_status_register_out[7] && serial_data_line_oe_out
      && $rose(serial_clock_line_oe_out) |-> low_cnt_reg >= hold_cyc) else $error("hold short");
   a_stop_setup_time: assert property (bus_status_register_out[7] && serial_clock_line_in
      && $fell(serial_data_line_oe_out) |-> high_cnt_reg >= hold_cyc) else $error("setup short");
   a_irq_one_cycle: assert property (bus_event_interrupt_out |=> !bus_event_interrupt_out)
      else $error("interrupt longer than one cycle");
   a_open_drain_low: assert property (!serial_clock_line_out && !serial_data_line_out)
      else $error("pin driven high");
   a_master_after_start: assert property ($rose(bus_status_register_out[7])
      |-> serial_data_line_oe_out && !serial_clock_line_oe_out) else $error("master flag early");
   a_wait_has_owner: assert property (wait_active_out [*2]
      |-> bus_status_register_out[7] || bus_status_register_out[4]) else $error("stray wait");
   a_tx_keeps_wait: assert property (wait_active_out && bus_status_register_out[3]
      && wait_release_bit_in && !shift_write_in |=> wait_active_out) else $error("tx released");
   a_stop_pulls_data: assert property (stop_trigger_bit_in && wait_active_out
      && bus_status_register_out[7] |-> ##[1:4] serial_data_line_oe_out) else $error("no stop");
endmodule
bind tsq_transfer_sequencer tsq_transfer_sequencer_properties u_props (.clk_in, .reset_in,
   .serial_clock_line_in, .serial_clock_line_out, .serial_clock_line_oe_out,
   .serial_data_line_out, .serial_data_line_oe_out, .stop_trigger_bit_in, .wait_release_bit_in,
   .shift_write_in, .fast_mode_in, .bus_status_register_out, .wait_active_out,
   .bus_event_interrupt_out);
`default_nettype wire

/* File: tsq_slave_model.sv */
// Behavioural slave on the two-wire bus that acks its address and collects bytes
`default_nettype none
module tsq_slave_model #(
   parameter logic [6:0] ADDR = 7'h2a
) (
   // Bus wires and stretch request
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic stretch_in,
   // Open-drain pulls and received data
   output logic scl_oe_out,
   output logic sda_oe_out,
   output logic [7:0] rx_byte_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh = 8'h00;
   int bit_n = 0;
   logic first = 0;
   logic sel = 0;
   initial {scl_oe_out, sda_oe_out, rx_byte_out} = 10'h000;
   // Start and stop are data edges while the clock is high
   always @(negedge sda_in) if (scl_in) {bit_n, first, sel} = {32'h0, 2'b11};
   always @(posedge sda_in) if (scl_in) {bit_n, sel} = {32'h0, 1'b0};
   // Data sampled at the first eight clock rises of a selected byte
   always @(posedge scl_in) if (sel && bit_n < 8) begin
      sh = {sh[6:0], sda_in};
      bit_n++;
   end
   // Ack after the eighth fall, dropped at the ninth, optional stretch
   always @(negedge scl_in) if (sel) begin
      if (bit_n == 8) begin
         sda_oe_out = first ? (sh[7:1] == ADDR) : 1'b1;
         if (!sda_oe_out) sel = 0;
         bit_n = 9;
      end else if (bit_n == 9) begin
         sda_oe_out = 0;
         bit_n = 0;
         if (!first) rx_byte_out = sh;
         first = 0;
         if (stretch_in) begin
            scl_oe_out = 1;
            #3000;
            scl_oe_out = 0;
         end
      end
   end
endmodule
`default_nettype wire

/* File: tsq_transfer_sequencer_tb.sv */
// Self-checking bench: the sequencer as master writes bytes to a model slave
`default_nettype none
module tsq_transfer_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] SLV = 7'h2a;
   logic clk_in = 0, reset_in = 1, link_clk = 0, seen = 0;
   logic st = 0, sp = 0, rel = 0, wr = 0, stretch = 0, sie = 0, fm = 0;
   logic [7:0] wdata = 8'h00, shift_q, stat, rx_b;
   logic [31:0] rnd = 32'h0001_06cf;
   logic scl_oe, sda_oe, s_scl_oe, s_sda_oe, wt, irq;
   wire logic scl_w = !(scl_oe | s_scl_oe);
   wire logic sda_w = !(sda_oe | s_sda_oe);
   int fails = 0, check_count = 0;
   logic [7:0] exp_q[$];
   initial forever #4 clk_in = ~clk_in;
   initial begin
      #3;
      forever #15 link_clk = ~link_clk;
   end
   tsq_transfer_sequencer DUT (.clk_in, .reset_in, .link_clk_in(link_clk),
      .serial_clock_line_in(scl_w), .serial_clock_line_out(), .serial_clock_line_oe_out(scl_oe),
      .serial_data_line_in(sda_w), .serial_data_line_out(), .serial_data_line_oe_out(sda_oe),
      .start_trigger_bit_in(st), .stop_trigger_bit_in(sp), .wait_release_bit_in(rel),
      .shift_write_in(wr), .shift_write_data_in(wdata), .ack_enable_bit_in(1'b1),
      .wait_timing_select_in(1'b1), .stop_interrupt_enable_in(sie), .fast_mode_in(fm),
      .own_slave_address_in({1'b1, rnd[5:0]}), .serial_shift_register_out(shift_q),
      .bus_status_register_out(stat), .wait_active_out(wt), .bus_event_interrupt_out(irq));
   tsq_slave_model #(.ADDR(SLV)) u_slave (.scl_in(scl_w), .sda_in(sda_w), .stretch_in(stretch),
      .scl_oe_out(s_scl_oe), .sda_oe_out(s_sda_oe), .rx_byte_out(rx_b));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic finish_test();
      if (fails == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One-cycle software pulse: 0 start, 1 stop, 2 write, 3 release
   task automatic pulse(input int k);
      @(negedge clk_in);
      {st, sp, wr, rel} = {k == 0, k == 1, k == 2, k == 3};
      @(negedge clk_in);
      {st, sp, wr, rel} = 4'h0;
   endtask
   // Bounded wait: 0 interrupt, 1 wait held, 2 stop seen
   task automatic wait_ev(input int m);
      int n;
      seen = 0;
      for (n = 0; n < 40000; n++) begin
         @(posedge clk_in);
         seen |= irq;
         if (((m == 0) ? irq : (m == 1) ? wt : stat[0]) === 1'b1) break;
      end
      if (n == 40000) begin
         fails++;
         finish_test();
      end
      repeat (2) begin
         @(negedge clk_in);
         seen |= irq;
      end
   endtask
   // Start, address, n data bytes, stop
   task automatic frame(input logic [6:0] a, input int n, input logic ack_exp);
      pulse(0);
      wait_ev(1);
      chk("master", 8'h82, stat);
      wdata = {a, 1'b0};
      pulse(2);
      wait_ev(0);
      chk("ack", {5'h0, ack_exp, 2'h0}, stat & 8'h04);
      chk("dir", {5'h11, ack_exp, 2'h2}, stat);
      chk("addr", {a, 1'b0}, shift_q);
      for (int i = 0; i < n; i++) begin
         rnd = lfsr(rnd);
         exp_q.push_back(rnd[7:0]);
         stretch = rnd[8];
         if (i == 0) begin
            pulse(3);
            repeat (20) @(negedge clk_in);
            chk("held", 8'h01, {7'h0, wt});
         end
         wdata = rnd[7:0];
         pulse(2);
         wait_ev(0);
         chk("ackd", 8'h04, stat & 8'h04);
         chk("shift", rnd[7:0], shift_q);
         chk("byte", exp_q.pop_front(), rx_b);
      end
      sie = rnd[9];
      pulse(1);
      wait_ev(2);
      chk("stop", 8'h01, stat);
      chk("stopirq", {7'h0, sie}, {7'h0, seen});
   endtask
   // Main sequence
   initial begin
      repeat (3) @(negedge clk_in);
      reset_in = 0;
      repeat (2) @(negedge clk_in);
      chk("status", 8'h00, stat);
      chk("shift", 8'hff, shift_q);
      frame(7'h15, 0, 1'b0);
      fm = 1;
      frame(SLV, 3, 1'b1);
      finish_test();
   end
endmodule
`default_nettype wire
